// ---- inc/pfc_pkg.sv ----
// pfc_pkg: constants and types for the parallel flash host controller.
// assumes a 128K x 8 asynchronous flash on the far side of the pins.
package pfc_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;              // byte address width
    localparam int DATA_W = 8;               // byte width

    // ------------------------------------------------------------------
    // command sequence patterns
    // ------------------------------------------------------------------
    localparam logic [16:0] CMD_ADDR_A = 17'h05555;
    localparam logic [16:0] CMD_ADDR_B = 17'h02AAA;
    localparam logic [7:0]  CMD_D_AA   = 8'hAA;
    localparam logic [7:0]  CMD_D_55   = 8'h55;
    localparam logic [7:0]  CMD_D_80   = 8'h80;
    localparam logic [7:0]  CMD_D_CHIP = 8'h10;
    localparam logic [7:0]  CMD_D_LOCK = 8'h40;
    localparam logic [7:0]  CMD_D_PROG = 8'hA0;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam int          TOGGLE_BIT  = 6;
    localparam int          POLL_BIT    = 7;

    // ------------------------------------------------------------------
    // timing at 200 MHz
    // ------------------------------------------------------------------
    localparam int CLK_MHZ     = 200;
    localparam int T_WP_NS     = 50;         // strobe low time, least
    localparam int T_SETUP_NS  = 20;         // address/data setup, least
    localparam int T_HOLD_NS   = 20;         // hold after rise, least
    localparam int T_ACC_NS    = 60;         // read access, least wait
    localparam int WP_CYC  = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int SU_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int HD_CYC  = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int FULL_ERASE_TIME_MS = 10000; // full_erase_time bound
    localparam int FULL_ERASE_CYC = FULL_ERASE_TIME_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 32;

    // ------------------------------------------------------------------
    // operations and pin bundle
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFC_OP_READ  = 2'h0,
        PFC_OP_PROG  = 2'h1,
        PFC_OP_CHIP  = 2'h2,
        PFC_OP_LOCK  = 2'h3
    } pfc_op_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        reset_n;
        logic [16:0] byte_address;
        logic [7:0]  data_byte;
        logic        data_oe;
    } pfc_pins_t;

endpackage : pfc_pkg

// ---- src/pfc_sync.sv ----
// pfc_sync: three-stage synchroniser for the returning data byte.
// assumes the byte changes only while the strobes are settled.
`timescale 1ns/10ps
`default_nettype none
module pfc_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // pin side
    input  wire logic [W-1:0] din,
    // synchronised side
    output var  logic [W-1:0] dout
);
    // -----------------------------------------------------------------
    // stages
    // -----------------------------------------------------------------
    logic [W-1:0] s1_r, s2_r, s3_r;         // stage one read by s2 only
    logic [W-1:0] dout_r, dout_nxt;         // accepted value

    // accept a bit once stages two and three agree
    always_comb begin
        dout_nxt = dout_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                dout_nxt[i] = s3_r[i];
            end
        end
    end

    // register the chain
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            dout_r <= '0;
        end else begin
            s1_r   <= din;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;
endmodule : pfc_sync
`default_nettype wire

// ---- src/pfc_host.sv ----
// pfc_host: host controller driving a parallel flash over its pins.
// assumes one requester on ref_clk; flash pins wired straight out.
`timescale 1ns/10ps
`default_nettype none
module pfc_host #(
    parameter int unsigned ERASE_CYC = pfc_pkg::FULL_ERASE_CYC
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    // request side
    input  wire logic                       req_valid,
    input  wire pfc_pkg::pfc_op_t           req_op,
    input  wire logic [pfc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [pfc_pkg::DATA_W-1:0] req_data,
    input  wire logic                       flash_reset_req,
    output var  logic                       req_ready,
    output var  logic                       rsp_valid,
    output var  logic [pfc_pkg::DATA_W-1:0] rsp_data,
    output var  logic                       rsp_timeout,
    // flash pins
    output var  pfc_pkg::pfc_pins_t         pins,
    input  wire logic [pfc_pkg::DATA_W-1:0] data_byte_in
);
    // -----------------------------------------------------------------
    // states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_STRB  = 3'b011,
        ST_HOLD  = 3'b010,
        ST_RDACC = 3'b110,
        ST_POLL  = 3'b111,
        ST_RST   = 3'b101
    } pfc_st_t;

    pfc_st_t                        st_r, st_nxt;
    pfc_pkg::pfc_pins_t             pins_r, pins_nxt;
    pfc_pkg::pfc_op_t               op_r, op_nxt;
    logic [pfc_pkg::ADDR_W-1:0]     addr_r, addr_nxt;   // target address
    logic [pfc_pkg::DATA_W-1:0]     data_r, data_nxt;   // target data
    logic [2:0]                     step_r, step_nxt;   // write step
    logic [7:0]                     cyc_r, cyc_nxt;     // phase counter
    logic [pfc_pkg::CNT_W-1:0]      wait_r, wait_nxt;   // busy timer
    logic                           last_tog_r, last_tog_nxt;
    logic                           have_tog_r, have_tog_nxt;
    logic                           ready_r, ready_nxt;
    logic                           rv_r, rv_nxt;
    logic [pfc_pkg::DATA_W-1:0]     rd_r, rd_nxt;
    logic                           to_r, to_nxt;
    logic [pfc_pkg::DATA_W-1:0]     din_s;              // synced data
    logic [2:0]                     nsteps;             // writes per op
    logic [pfc_pkg::ADDR_W-1:0]     step_addr;
    logic [pfc_pkg::DATA_W-1:0]     step_data;

    // -----------------------------------------------------------------
    // data return synchroniser
    // -----------------------------------------------------------------
    pfc_sync #(.W(pfc_pkg::DATA_W)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (data_byte_in),
        .dout    (din_s)
    );

    // step pattern of each command sequence
    always_comb begin
        nsteps = (op_r == pfc_pkg::PFC_OP_PROG) ? 3'h4 : 3'h6;
        step_addr = pfc_pkg::CMD_ADDR_A;
        step_data = pfc_pkg::CMD_D_AA;
        unique case (step_r)
            3'h0: step_data = pfc_pkg::CMD_D_AA;
            3'h1: begin
                step_addr = pfc_pkg::CMD_ADDR_B;
                step_data = pfc_pkg::CMD_D_55;
            end
            3'h2: step_data = (op_r == pfc_pkg::PFC_OP_PROG) ?
                              pfc_pkg::CMD_D_PROG : pfc_pkg::CMD_D_80;
            3'h3: begin
                if (op_r == pfc_pkg::PFC_OP_PROG) begin
                    step_addr = addr_r;
                    step_data = data_r;
                end else begin
                    step_data = pfc_pkg::CMD_D_AA;
                end
            end
            3'h4: begin
                step_addr = pfc_pkg::CMD_ADDR_B;
                step_data = pfc_pkg::CMD_D_55;
            end
            3'h5: step_data = (op_r == pfc_pkg::PFC_OP_LOCK) ?
                              pfc_pkg::CMD_D_LOCK : pfc_pkg::CMD_D_CHIP;
            default: step_data = pfc_pkg::CMD_D_AA;
        endcase
    end

    // -----------------------------------------------------------------
    // sequencer next state
    // -----------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        pins_nxt     = pins_r;
        op_nxt       = op_r;
        addr_nxt     = addr_r;
        data_nxt     = data_r;
        step_nxt     = step_r;
        cyc_nxt      = cyc_r;
        wait_nxt     = wait_r;
        last_tog_nxt = last_tog_r;
        have_tog_nxt = have_tog_r;
        ready_nxt    = 1'b0;
        rv_nxt       = 1'b0;
        rd_nxt       = rd_r;
        to_nxt       = 1'b0;
        unique case (st_r)
            ST_IDLE: begin
                ready_nxt = ~req_valid;
                if (flash_reset_req) begin
                    // reset low floats the device; host stops driving
                    pins_nxt.reset_n = 1'b0;
                    pins_nxt.data_oe = 1'b0;
                    cyc_nxt = '0;
                    st_nxt  = ST_RST;
                end else if (req_valid && ready_r) begin
                    op_nxt   = req_op;
                    addr_nxt = req_addr;
                    // program only clears bits; caller erases first
                    data_nxt = req_data;
                    step_nxt = '0;
                    cyc_nxt  = '0;
                    ready_nxt = 1'b0;
                    if (req_op == pfc_pkg::PFC_OP_READ) begin
                        // read: chip and output low, write high
                        pins_nxt.byte_address = req_addr;
                        pins_nxt.data_oe = 1'b0;
                        pins_nxt.ce_n = 1'b0;
                        pins_nxt.oe_n = 1'b0;
                        st_nxt = ST_RDACC;
                    end else begin
                        st_nxt = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // output drive high before any write strobe
                pins_nxt.oe_n = 1'b1;
                pins_nxt.ce_n = 1'b0;
                pins_nxt.byte_address = step_addr;
                pins_nxt.data_byte = step_data;
                pins_nxt.data_oe = 1'b1;
                cyc_nxt = cyc_r + 8'h01;
                if (cyc_r >= 8'(pfc_pkg::SU_CYC)) begin
                    pins_nxt.we_n = 1'b0;
                    cyc_nxt = '0;
                    st_nxt  = ST_STRB;
                end
            end
            ST_STRB: begin
                cyc_nxt = cyc_r + 8'h01;
                if (cyc_r >= 8'(pfc_pkg::WP_CYC)) begin
                    // rising write strobe latches the byte
                    pins_nxt.we_n = 1'b1;
                    cyc_nxt = '0;
                    st_nxt  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                cyc_nxt = cyc_r + 8'h01;
                if (cyc_r >= 8'(pfc_pkg::HD_CYC)) begin
                    cyc_nxt = '0;
                    pins_nxt.data_oe = 1'b0;
                    pins_nxt.ce_n = 1'b1;
                    if (step_r == nsteps - 3'h1) begin
                        // sequence done: watch status while busy
                        wait_nxt = '0;
                        have_tog_nxt = 1'b0;
                        st_nxt = ST_POLL;
                    end else begin
                        step_nxt = step_r + 3'h1;
                        st_nxt = ST_SETUP;
                    end
                end
            end
            ST_RDACC: begin
                cyc_nxt = cyc_r + 8'h01;
                // busy limit counts whole cycles, reads included
                wait_nxt = wait_r + 32'h1;
                // wait access plus synchroniser depth
                if (cyc_r >= 8'(pfc_pkg::ACC_CYC + 4)) begin
                    pins_nxt.ce_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    cyc_nxt = '0;
                    if (op_r == pfc_pkg::PFC_OP_READ) begin
                        rv_nxt = 1'b1;
                        rd_nxt = din_s;
                        ready_nxt = 1'b0;
                        st_nxt = ST_IDLE;
                    end else begin
                        // busy read: compare toggle with previous
                        if (have_tog_r &&
                            din_s[pfc_pkg::TOGGLE_BIT] ==
                            last_tog_r) begin
                            rv_nxt = 1'b1;
                            rd_nxt = din_s;
                            st_nxt = ST_IDLE;
                        end else begin
                            last_tog_nxt = din_s[pfc_pkg::TOGGLE_BIT];
                            have_tog_nxt = 1'b1;
                            st_nxt = ST_POLL;
                        end
                    end
                end
            end
            ST_POLL: begin
                // no command writes while busy; only status reads
                wait_nxt = wait_r + 32'h1;
                cyc_nxt = cyc_r + 8'h01;
                if (wait_r >= ERASE_CYC) begin
                    rv_nxt = 1'b1;
                    to_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end else if (cyc_r >= 8'(pfc_pkg::HD_CYC)) begin
                    pins_nxt.byte_address = addr_r;
                    pins_nxt.ce_n = 1'b0;
                    pins_nxt.oe_n = 1'b0;
                    cyc_nxt = '0;
                    st_nxt = ST_RDACC;
                end
            end
            ST_RST: begin
                cyc_nxt = cyc_r + 8'h01;
                pins_nxt.ce_n = 1'b1;
                pins_nxt.oe_n = 1'b1;
                pins_nxt.we_n = 1'b1;
                if (!flash_reset_req && cyc_r >= 8'(pfc_pkg::WP_CYC)) begin
                    // release into read or standby by control levels
                    pins_nxt.reset_n = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // register sequencer state; active-low pins idle high, deselected
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r       <= ST_IDLE;
            pins_r     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                            reset_n: 1'b1, byte_address: '0,
                            data_byte: '0, data_oe: 1'b0};
            op_r       <= pfc_pkg::PFC_OP_READ;
            addr_r     <= '0;
            data_r     <= '0;
            step_r     <= '0;
            cyc_r      <= '0;
            wait_r     <= '0;
            last_tog_r <= 1'b0;
            have_tog_r <= 1'b0;
            ready_r    <= 1'b0;
            rv_r       <= 1'b0;
            rd_r       <= '0;
            to_r       <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            pins_r     <= pins_nxt;
            op_r       <= op_nxt;
            addr_r     <= addr_nxt;
            data_r     <= data_nxt;
            step_r     <= step_nxt;
            cyc_r      <= cyc_nxt;
            wait_r     <= wait_nxt;
            last_tog_r <= last_tog_nxt;
            have_tog_r <= have_tog_nxt;
            ready_r    <= ready_nxt;
            rv_r       <= rv_nxt;
            rd_r       <= rd_nxt;
            to_r       <= to_nxt;
        end
    end

    // outputs straight from flops
    assign pins        = pins_r;
    assign req_ready   = ready_r;
    assign rsp_valid   = rv_r;
    assign rsp_data    = rd_r;
    assign rsp_timeout = to_r;
endmodule : pfc_host
`default_nettype wire

// ---- sim/pfc_host_properties.sv ----
// pfc_host_properties: timing checks on the flash pin sequencing.
// assumes it is bound to pfc_host and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pfc_host_properties #(
    parameter int unsigned ERASE_CYC = 5000
) (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       nrst,
    // request side
    input wire logic                       req_valid,
    input wire pfc_pkg::pfc_op_t           req_op,
    input wire logic [pfc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [pfc_pkg::DATA_W-1:0] req_data,
    input wire logic                       flash_reset_req,
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic [pfc_pkg::DATA_W-1:0] rsp_data,
    input wire logic                       rsp_timeout,
    // flash pins
    input wire pfc_pkg::pfc_pins_t         pins,
    input wire logic [pfc_pkg::DATA_W-1:0] data_byte_in
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // strobe low time: ten cycles at least
    sequence s_we_held;
        (!pins.we_n)[*8] ##1 (!pins.we_n)[*2];
    endsequence
    // hold phase: chip stays selected after the strobe rises
    sequence s_hold;
        (!pins.ce_n)[*4];
    endsequence
    AST_RESET_IDLE: assert property (
        $rose(nrst) |-> pins.ce_n && pins.oe_n && pins.we_n
            && pins.reset_n && !pins.data_oe)
        else $error("pins not idle after reset");
    AST_WE_WIDTH: assert property ($fell(pins.we_n) |-> s_we_held)
        else $error("write strobe too short");
    AST_SETUP: assert property (
        $fell(pins.we_n) |-> $past(pins.ce_n, 4) == 1'b0)
        else $error("chip select not set up before strobe");
    AST_HOLD: assert property ($rose(pins.we_n) |-> s_hold)
        else $error("chip select dropped before hold ended");
    AST_WRITE_QUAL: assert property (
        !pins.we_n |-> !pins.ce_n && pins.oe_n && pins.data_oe)
        else $error("write strobe without select or drive");
    AST_STABLE: assert property (
        (!pins.we_n || !$past(pins.we_n)) |->
            $stable(pins.byte_address) && $stable(pins.data_byte))
        else $error("address or data moved around strobe");
    AST_READ_NO_DRIVE: assert property (
        !pins.oe_n |-> !pins.data_oe && pins.we_n)
        else $error("host drives bus during read");
    AST_READY_DROP: assert property (
        req_valid && req_ready |=> !req_ready)
        else $error("ready stayed high after a take");
    AST_RSP_ONCE: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    AST_TIMEOUT_VALID: assert property (rsp_timeout |-> rsp_valid)
        else $error("timeout without response");
    AST_FLASH_RST: assert property (
        flash_reset_req && req_ready |-> ##[1:3] !pins.reset_n)
        else $error("flash reset not driven");
    AST_RST_QUIET: assert property (!pins.reset_n |-> pins.we_n)
        else $error("write during flash reset");
endmodule : pfc_host_properties
`default_nettype wire

// ---- sim/pfc_flash_model.sv ----
// pfc_flash_model: behavioural 128K x 8 flash on the far pins.
// assumes the bench resolves the data wire from the host drive enable.
`timescale 1ns/10ps
`default_nettype none
module pfc_flash_model #(
    parameter logic [16:0] BOOT_LO = 17'h00000, // boot block bounds
    parameter logic [16:0] BOOT_HI = 17'h03FFF
) (
    input  wire pfc_pkg::pfc_pins_t pins, // host pin bundle
    output var  logic [7:0]         q     // byte put on the wire
);
    logic [7:0]  mem [0:131071];
    logic [16:0] lat_a;          // address of the current write
    logic [16:0] p_a;            // byte under program
    logic [7:0]  p_d;
    logic [2:0]  step;           // command sequence position
    logic        locked;
    logic        busy;
    logic        erasing;
    logic        tog;
    logic [7:0]  last;           // last byte shown, for float pattern
    int          op_id;          // bumped on reset to kill a timer
    realtime     erase_ns = 10000.0;
    realtime     prog_ns  = 500.0;
    wire wr = !pins.ce_n && !pins.we_n && pins.oe_n && pins.reset_n;
    wire rd = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_n;
    wire [7:0] drv = busy ? {erasing ? 1'b0 : ~p_d[7], tog, 6'h00}
                          : mem[pins.byte_address];
    // power-up contents: a pattern, so erase is visible
    initial begin
        for (int i = 0; i < 131072; i++)
            mem[i] = i[7:0] ^ 8'h3C;
        step = 3'h0;
        locked = 1'b0;
        busy = 1'b0;
        erasing = 1'b0;
        tog = 1'b0;
        last = 8'h00;
        op_id = 0;
    end
    // internally timed work; a reset meanwhile leaves it undone
    task automatic run_op(input logic er, input realtime t);
        int id;
        op_id++;
        id = op_id;
        busy = 1'b1;
        erasing = er;
        #(t);
        if (id == op_id) begin
            busy = 1'b0;
            if (er) begin
                for (int i = 0; i < 131072; i++)
                    if (!(locked && i >= BOOT_LO && i <= BOOT_HI))
                        mem[i] = 8'hFF;
            end else if (!(locked && p_a <= BOOT_HI)) begin
                mem[p_a] = mem[p_a] & p_d;
            end
        end
    endtask
    // command decoder; the array is never touched by the steps
    task automatic cmd(input logic [7:0] d);
        logic a5;
        logic a2;
        a5 = (lat_a == 17'h05555);
        a2 = (lat_a == 17'h02AAA);
        if (step == 3'h6) begin
            p_a = lat_a;
            p_d = d;
            step = 3'h0;
            fork run_op(1'b0, prog_ns); join_none
        end else if (step == 3'h2 && a5 && d == 8'hA0) begin
            step = 3'h6;
        end else if (step == 3'h5 && a5 && d == 8'h10) begin
            step = 3'h0;
            fork run_op(1'b1, erase_ns); join_none
        end else if (step == 3'h5 && a5 && d == 8'h40) begin
            step = 3'h0;
            locked = 1'b1;
        end else if (((step == 3'h0 || step == 3'h3) && a5 && d == 8'hAA)
            || ((step == 3'h1 || step == 3'h4) && a2 && d == 8'h55)
            || (step == 3'h2 && a5 && d == 8'h80)) begin
            step = step + 3'h1;
        end else begin
            step = 3'h0;
        end
    endtask
    always @(posedge wr)
        lat_a = pins.byte_address;
    always @(negedge wr)
        if (pins.reset_n && !busy)
            cmd(pins.data_byte);
    always @(posedge rd)
        if (busy)
            tog = ~tog;
    always @(negedge rd)
        last = drv;
    // released wire shows the inverse, never a kind stale value
    assign q = rd ? drv : ~last;
    always @(negedge pins.reset_n) begin
        op_id++;
        busy = 1'b0;
        step = 3'h0;
    end
endmodule : pfc_flash_model
`default_nettype wire

// ---- sim/tb_pfc_host.sv ----
// tb_pfc_host: directed scenarios for the flash host controller.
// assumes pfc_flash_model on the pins and a 200 MHz ref_clk.
`timescale 1ns/10ps
`default_nettype none
module tb_pfc_host;
    localparam int unsigned ERASE_CYC = 5000; // shortened busy limit
    logic               ref_clk;
    logic               nrst;
    logic               req_valid;
    pfc_pkg::pfc_op_t   req_op;
    logic [16:0]        req_addr;
    logic [7:0]         req_data;
    logic               flash_reset_req;
    logic               req_ready;
    logic               rsp_valid;
    logic [7:0]         rsp_data;
    logic               rsp_timeout;
    pfc_pkg::pfc_pins_t pins;
    logic [7:0]         flash_q;
    logic [7:0]         got;
    logic               tmo;
    int                 n_fail;
    int                 n_compared;
    // wire level: whoever enables wins, flash otherwise
    wire logic [7:0] data_byte_in = pins.data_oe ? pins.data_byte : flash_q;
    pfc_host #(.ERASE_CYC(ERASE_CYC)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .flash_reset_req(flash_reset_req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_timeout(rsp_timeout), .pins(pins),
        .data_byte_in(data_byte_in));
    pfc_flash_model u_flash (.pins(pins), .q(flash_q));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] init_b(input logic [16:0] a);
        return a[7:0] ^ 8'h3C; // power-up pattern of the model
    endfunction : init_b
    // one request, held until taken, then wait for its answer
    task automatic do_req(input pfc_pkg::pfc_op_t op,
                          input logic [16:0] a, input logic [7:0] d);
        int k;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        req_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
        req_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (rsp_valid !== 1'b1 && k < 20000);
        got = rsp_data;
        tmo = rsp_timeout;
        if (k >= 20000 || rsp_valid !== 1'b1) begin
            n_fail++;
            complete_run();
        end
    endtask : do_req
    task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
        do_req(pfc_pkg::PFC_OP_READ, a, 8'h00);
        check(got, e);
    endtask : rd_chk
    task automatic t_reset();
        check({pins.ce_n, pins.oe_n, pins.we_n, pins.reset_n}, 4'hF);
        check(pins.data_oe, 1'b0);
    endtask : t_reset
    task automatic t_read();
        rd_chk(17'h1FFFF, 8'hC3);
        rd_chk(17'h00000, 8'h3C);
    endtask : t_read
    task automatic t_program();
        do_req(pfc_pkg::PFC_OP_PROG, 17'h10123, 8'h5A);
        check(tmo, 1'b0);
        rd_chk(17'h10123, init_b(17'h10123) & 8'h5A);
        rd_chk(17'h05555, init_b(17'h05555));
        rd_chk(17'h02AAA, init_b(17'h02AAA));
    endtask : t_program
    task automatic t_erase();
        do_req(pfc_pkg::PFC_OP_CHIP, 17'h00000, 8'h00);
        check(tmo, 1'b0);
        rd_chk(17'h00010, 8'hFF);
        rd_chk(17'h1FFFF, 8'hFF);
        rd_chk(17'h10123, 8'hFF);
    endtask : t_erase
    task automatic t_lock();
        do_req(pfc_pkg::PFC_OP_PROG, 17'h00020, 8'h12);
        do_req(pfc_pkg::PFC_OP_LOCK, 17'h00000, 8'h00);
        do_req(pfc_pkg::PFC_OP_PROG, 17'h00021, 8'h00);
        rd_chk(17'h00021, 8'hFF);
        do_req(pfc_pkg::PFC_OP_PROG, 17'h08000, 8'h00);
        do_req(pfc_pkg::PFC_OP_CHIP, 17'h00000, 8'h00);
        rd_chk(17'h00020, 8'h12);
        rd_chk(17'h08000, 8'hFF);
    endtask : t_lock
    task automatic t_abort();
        do_req(pfc_pkg::PFC_OP_PROG, 17'h0A000, 8'h77);
        u_flash.erase_ns = 60000.0; // longer than the busy limit
        do_req(pfc_pkg::PFC_OP_CHIP, 17'h00000, 8'h00);
        check(tmo, 1'b1);
        flash_reset_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(pins.reset_n, 1'b0);
        flash_reset_req <= 1'b0;
        // ready wants one idle cycle with no request pending
        repeat (12) @(posedge ref_clk);
        u_flash.erase_ns = 10000.0;
        rd_chk(17'h0A000, 8'h77);
        do_req(pfc_pkg::PFC_OP_CHIP, 17'h00000, 8'h00);
        check(tmo, 1'b0);
        rd_chk(17'h0A000, 8'hFF);
    endtask : t_abort
    // main sequence: reset five cycles, then the scenarios
    initial begin
        n_fail = 0;
        n_compared = 0;
        nrst = 1'b0;
        req_valid = 1'b0;
        req_op = pfc_pkg::PFC_OP_READ;
        req_addr = 17'h00000;
        req_data = 8'h00;
        flash_reset_req = 1'b0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_read();
        t_program();
        t_erase();
        t_lock();
        t_abort();
        complete_run();
    end
endmodule : tb_pfc_host
bind pfc_host pfc_host_properties #(.ERASE_CYC(ERASE_CYC)) u_props (
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .flash_reset_req(flash_reset_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .pins(pins),
    .data_byte_in(data_byte_in));
`default_nettype wire
